/* design/cvd_adc_consts.svh */
`ifndef CVD_ADC_CONSTS_SVH
`define CVD_ADC_CONSTS_SVH

`define ADDR_W            12
`define DATA_W            8
`define OFF_LEG_RES0L     12'h09B
`define OFF_LEG_RES0H     12'h09C
`define OFF_LEG_CTL0      12'h09D
`define OFF_LEG_CTL1      12'h09E
`define OFF_CTL0          12'h711
`define OFF_CTL1          12'h712
`define OFF_TRIG          12'h713
`define OFF_CTL3          12'h714
`define OFF_STAT          12'h715
`define OFF_PRE           12'h716
`define OFF_ACQ           12'h717
`define OFF_GRD           12'h718
`define OFF_CAP           12'h719
`define OFF_RES0L         12'h71A
`define OFF_RES0H         12'h71B
`define OFF_RES1L         12'h71C
`define OFF_RES1H         12'h71D

// Control 0
`define B_ENABLE          0
`define B_GO              1
`define F_CHS_HI          6
`define F_CHS_LO          2
// Control 1
`define B_JUSTIFY         7
`define F_CS_HI           6
`define F_CS_LO           4
`define F_REF_HI          1
`define F_REF_LO          0
// Trigger select
`define F_TRIG_HI         6
`define F_TRIG_LO         4
// Control 3
`define B_EXT_POL         7
`define B_INT_POL         6
`define B_LOWZ_EN         5
`define B_PIN_EN          4
`define B_OVR_EN          3
`define B_CTL3_RSVD       2
`define B_INVERT          1
`define B_DOUBLE          0
// Guard, capacitor, status
`define B_GRD_B_EN        7
`define B_GRD_A_EN        6
`define B_GRD_POL         5
`define F_CAP_HI          2
`define F_CAP_LO          0
`define B_STAT_SECOND     2
`define F_STG_HI          1
`define F_STG_LO          0

`define STG_IDLE          2'h0
`define STG_PRE           2'h1
`define STG_ACQ           2'h2
`define STG_CONV          2'h3

`define CNT_W             7
`define CLK_PERIOD_NS     50
`define INSTR_PERIOD_NS   200
// Whole clock cycles per instruction cycle, rounded up
`define INSTR_CLKS \
  ((`INSTR_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESC_W           2
`define DIV_W             7

`endif

/* design/cvd_adc_pkg.sv */
`include "cvd_adc_consts.svh"

package cvd_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_ACQ,
    ST_CONV
  } seq_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } bus_req_t;

  typedef struct packed {
    logic ccp1;
    logic ccp2;
    logic tmr0_ovf;
    logic tmr1_ovf;
    logic tmr2_match;
  } trig_src_t;

  typedef struct packed {
    logic [4:0]         input_channel_sel;
    logic               go;
    logic               converter_enable;
    logic               result_justify;
    logic [2:0]         conv_clock_sel;
    logic [1:0]         pos_reference_sel;
    logic [2:0]         auto_trigger_sel;
    logic [`DATA_W-1:0] ctl3;
    logic [`CNT_W-1:0]  precharge_count;
    logic [`CNT_W-1:0]  acquisition_count;
    logic [2:0]         guard;
    logic [2:0]         extra_cap;
    logic [`DATA_W-1:0] res0l;
    logic [`DATA_W-1:0] res0h;
    logic [`DATA_W-1:0] res1l;
    logic [`DATA_W-1:0] res1h;
    seq_t               seq;
    logic               second;
    logic [`CNT_W-1:0]  cnt;
    logic [`PRESC_W-1:0] presc;
    trig_src_t          trig_prev;
    logic               conv_start;
    logic               done;
    logic [`DATA_W-1:0] rdata;
  } state_t;

endpackage

/* design/cvd_adc_control_regs.sv */
`include "cvd_adc_consts.svh"

module cvd_adc_control_regs
  import cvd_adc_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  // Register port
  input  wire bus_req_t           i_bus,
  output logic [`DATA_W-1:0]      o_rdata,
  // Special event triggers
  input  wire trig_src_t          i_trig,
  // Converter core
  input  wire logic               i_rc_tick,
  input  wire logic               i_conv_done,
  input  wire logic [9:0]         i_conv_result,
  output logic                    o_converter_enable,
  output logic                    o_conv_start,
  output logic                    o_seq_done,
  output logic                    o_conv_clk_rc,
  output logic [`DIV_W-1:0]       o_conv_clk_div,
  output logic                    o_ref_vdd,
  output logic                    o_ref_ext,
  output logic                    o_ref_fixed,
  // Channel switches and sample-and-hold
  output logic [4:0]              o_channel_sel,
  output logic                    o_channel_connect,
  output logic                    o_ext_precharge_en,
  output logic                    o_ext_precharge_high,
  output logic                    o_int_precharge_en,
  output logic                    o_int_precharge_high,
  output logic [2:0]              o_extra_cap_sel,
  // Analog bus pin and guard drives
  output logic                    o_bus_pin_lowz_sw,
  output logic                    o_bus_pin_sw,
  output logic                    o_analog_bus_pin_out,
  output logic                    o_analog_bus_pin_oe,
  output logic                    o_guard_a,
  output logic                    o_guard_a_oe,
  output logic                    o_guard_b,
  output logic                    o_guard_b_oe
);

  state_t s_r;
  state_t s_nxt;

  // Legacy offsets fold onto the extended ones
  function automatic logic [`ADDR_W-1:0] canon(input logic [`ADDR_W-1:0] a);
    unique case (a)
      `OFF_LEG_RES0L: canon = `OFF_RES0L;
      `OFF_LEG_RES0H: canon = `OFF_RES0H;
      `OFF_LEG_CTL0:  canon = `OFF_CTL0;
      `OFF_LEG_CTL1:  canon = `OFF_CTL1;
      default:        canon = a;
    endcase
  endfunction

  function automatic logic chan_valid(input logic [4:0] c);
    unique case (c)
      5'h05, 5'h06, 5'h07, 5'h14, 5'h15, 5'h16, 5'h17,
      5'h18, 5'h19, 5'h1C, 5'h1E: chan_valid = 1'b0;
      default:                    chan_valid = 1'b1;
    endcase
  endfunction

  function automatic logic [1:0] stage_code(input seq_t q);
    unique case (q)
      ST_IDLE: stage_code = `STG_IDLE;
      ST_PRE:  stage_code = `STG_PRE;
      ST_ACQ:  stage_code = `STG_ACQ;
      ST_CONV: stage_code = `STG_CONV;
    endcase
  endfunction

  // First stage of a sample; empty stages are skipped
  function automatic seq_t first_stage(input logic [`CNT_W-1:0] pre,
                                       input logic [`CNT_W-1:0] acq);
    if (pre != '0) begin
      first_stage = ST_PRE;
    end else if (acq != '0) begin
      first_stage = ST_ACQ;
    end else begin
      first_stage = ST_CONV;
    end
  endfunction

  // Count loaded when a sample starts
  function automatic logic [`CNT_W-1:0] first_count(
      input logic [`CNT_W-1:0] pre,
      input logic [`CNT_W-1:0] acq);
    if (pre != '0) begin
      first_count = pre;
    end else begin
      first_count = acq;
    end
  endfunction

  // Both timers zero: conversion starts with no wait
  function automatic logic no_wait(input logic [`CNT_W-1:0] pre,
                                   input logic [`CNT_W-1:0] acq);
    no_wait = (pre == '0) && (acq == '0);
  endfunction

  logic [`ADDR_W-1:0] addr_c;
  logic               tick;
  logic               trig_edge;
  logic               invert;
  logic [9:0]         res_hi_lo;
  logic [`DATA_W-1:0] fmt_h;
  logic [`DATA_W-1:0] fmt_l;
  logic [`DATA_W-1:0] rd_val;
  trig_src_t          trig_rise;

  always_comb begin
    addr_c = canon(i_bus.addr);
    // RC clock also paces the stage timers when selected
    // Instruction tick
    if (o_conv_clk_rc) begin
      tick = i_rc_tick;
    end else begin
      tick = (s_r.presc == `PRESC_W'(`INSTR_CLKS - 1));
    end
    trig_rise = i_trig & ~s_r.trig_prev;
    unique case (s_r.auto_trigger_sel)
      3'h1:    trig_edge = trig_rise.ccp1;
      3'h2:    trig_edge = trig_rise.ccp2;
      3'h3:    trig_edge = trig_rise.tmr0_ovf;
      3'h4:    trig_edge = trig_rise.tmr1_ovf;
      3'h5:    trig_edge = trig_rise.tmr2_match;
      default: trig_edge = 1'b0;
    endcase
    invert = s_r.ctl3[`B_DOUBLE] & s_r.ctl3[`B_INVERT] & s_r.second;
    res_hi_lo = i_conv_result;
    if (s_r.result_justify) begin
      fmt_h = {6'h00, res_hi_lo[9:8]};
      fmt_l = res_hi_lo[7:0];
    end else begin
      fmt_h = res_hi_lo[9:2];
      fmt_l = {res_hi_lo[1:0], 6'h00};
    end
  end

  // Readback with unimplemented bits as zero
  always_comb begin
    rd_val = '0;
    unique case (addr_c)
      `OFF_CTL0: begin
        rd_val[`F_CHS_HI:`F_CHS_LO] = s_r.input_channel_sel;
        rd_val[`B_GO]               = s_r.go;
        rd_val[`B_ENABLE]           = s_r.converter_enable;
      end
      `OFF_CTL1: begin
        rd_val[`B_JUSTIFY]          = s_r.result_justify;
        rd_val[`F_CS_HI:`F_CS_LO]   = s_r.conv_clock_sel;
        rd_val[`F_REF_HI:`F_REF_LO] = s_r.pos_reference_sel;
      end
      `OFF_TRIG:  rd_val[`F_TRIG_HI:`F_TRIG_LO] = s_r.auto_trigger_sel;
      `OFF_CTL3:  rd_val = s_r.ctl3;
      `OFF_STAT: begin
        rd_val[`F_STG_HI:`F_STG_LO] = stage_code(s_r.seq);
        rd_val[`B_STAT_SECOND] = s_r.second;
      end
      `OFF_PRE:   rd_val[`CNT_W-1:0] = s_r.precharge_count;
      `OFF_ACQ:   rd_val[`CNT_W-1:0] = s_r.acquisition_count;
      `OFF_GRD:   rd_val[`B_GRD_B_EN:`B_GRD_POL] = s_r.guard;
      `OFF_CAP:   rd_val[`F_CAP_HI:`F_CAP_LO] = s_r.extra_cap;
      `OFF_RES0L: rd_val = s_r.res0l;
      `OFF_RES0H: rd_val = s_r.res0h;
      `OFF_RES1L: rd_val = s_r.res1l;
      `OFF_RES1H: rd_val = s_r.res1h;
      default:    rd_val = '0;
    endcase
  end

  always_comb begin
    s_nxt            = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.done       = 1'b0;
    s_nxt.trig_prev  = i_trig;
    s_nxt.rdata      = i_bus.rd ? rd_val : '0;
    s_nxt.presc      = (tick || o_conv_clk_rc) ? '0
                       : s_r.presc + `PRESC_W'(1);

    // Sequencer
    unique case (s_r.seq)
      ST_IDLE: begin
        s_nxt.second = 1'b0;
        if (s_r.go && s_r.converter_enable) begin
          s_nxt.seq   = first_stage(s_r.precharge_count,
                                    s_r.acquisition_count);
          s_nxt.cnt   = first_count(s_r.precharge_count,
                                    s_r.acquisition_count);
          s_nxt.presc = '0;
          s_nxt.conv_start = no_wait(s_r.precharge_count,
                                     s_r.acquisition_count);
        end
      end
      ST_PRE: begin
        if (tick && s_r.cnt == `CNT_W'(1)) begin
          if (s_r.acquisition_count != '0) begin
            s_nxt.seq = ST_ACQ;
            s_nxt.cnt = s_r.acquisition_count;
          end else begin
            s_nxt.seq        = ST_CONV;
            s_nxt.conv_start = 1'b1;
          end
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end
      end
      ST_ACQ: begin
        if (tick && s_r.cnt == `CNT_W'(1)) begin
          s_nxt.seq        = ST_CONV;
          s_nxt.conv_start = 1'b1;
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end
      end
      ST_CONV: begin
        if (i_conv_done) begin
          if (s_r.second) begin
            s_nxt.res1h = fmt_h;
            s_nxt.res1l = fmt_l;
          end else begin
            s_nxt.res0h = fmt_h;
            s_nxt.res0l = fmt_l;
          end
          if (s_r.ctl3[`B_DOUBLE] && !s_r.second) begin
            s_nxt.second = 1'b1;
            s_nxt.seq    = first_stage(s_r.precharge_count,
                                       s_r.acquisition_count);
            s_nxt.cnt    = first_count(s_r.precharge_count,
                                       s_r.acquisition_count);
            s_nxt.presc  = '0;
            s_nxt.conv_start = no_wait(s_r.precharge_count,
                                       s_r.acquisition_count);
          end else begin
            s_nxt.seq  = ST_IDLE;
            s_nxt.go   = 1'b0;
            s_nxt.done = 1'b1;
          end
        end
      end
    endcase

    // Clearing the bit or disabling aborts with no done pulse; a core result arriving in that cycle is still stored
    if (s_r.seq != ST_IDLE && (!s_r.go || !s_r.converter_enable)) begin
      s_nxt.seq        = ST_IDLE;
      s_nxt.go         = 1'b0;
      s_nxt.conv_start = 1'b0;
      s_nxt.done       = 1'b0;
    end

    // Event pulse from the source sets the in-progress bit
    if (trig_edge && s_r.converter_enable && s_r.seq == ST_IDLE) begin
      s_nxt.go = 1'b1;
    end

    // Software writes land last so a set beats the hardware clear
    if (i_bus.wr) begin
      unique case (addr_c)
        `OFF_CTL0: begin
          s_nxt.input_channel_sel = i_bus.wdata[`F_CHS_HI:`F_CHS_LO];
          s_nxt.go                = i_bus.wdata[`B_GO];
          s_nxt.converter_enable  = i_bus.wdata[`B_ENABLE];
        end
        `OFF_CTL1: begin
          s_nxt.result_justify    = i_bus.wdata[`B_JUSTIFY];
          s_nxt.conv_clock_sel    = i_bus.wdata[`F_CS_HI:`F_CS_LO];
          s_nxt.pos_reference_sel = i_bus.wdata[`F_REF_HI:`F_REF_LO];
        end
        `OFF_TRIG: s_nxt.auto_trigger_sel =
                     i_bus.wdata[`F_TRIG_HI:`F_TRIG_LO];
        // Stored polarity bits only change here
        `OFF_CTL3: begin
          s_nxt.ctl3    = i_bus.wdata;
          s_nxt.ctl3[`B_CTL3_RSVD] = 1'b0;
        end
        `OFF_PRE:   s_nxt.precharge_count   = i_bus.wdata[`CNT_W-1:0];
        `OFF_ACQ:   s_nxt.acquisition_count = i_bus.wdata[`CNT_W-1:0];
        `OFF_GRD:   s_nxt.guard = i_bus.wdata[`B_GRD_B_EN:`B_GRD_POL];
        `OFF_CAP:   s_nxt.extra_cap = i_bus.wdata[`F_CAP_HI:`F_CAP_LO];
        `OFF_RES0L: s_nxt.res0l = i_bus.wdata;
        `OFF_RES0H: s_nxt.res0h = i_bus.wdata;
        `OFF_RES1L: s_nxt.res1l = i_bus.wdata;
        `OFF_RES1H: s_nxt.res1h = i_bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_rdata            = s_r.rdata;
    o_conv_start       = s_r.conv_start;
    o_seq_done         = s_r.done;
    o_converter_enable = s_r.converter_enable;
  end

  always_comb begin
    o_conv_clk_rc      = (s_r.conv_clock_sel[1:0] == 2'h3);
    unique case (s_r.conv_clock_sel)
      3'h0:    o_conv_clk_div = `DIV_W'(2);
      3'h1:    o_conv_clk_div = `DIV_W'(8);
      3'h2:    o_conv_clk_div = `DIV_W'(32);
      3'h4:    o_conv_clk_div = `DIV_W'(4);
      3'h5:    o_conv_clk_div = `DIV_W'(16);
      3'h6:    o_conv_clk_div = `DIV_W'(64);
      default: o_conv_clk_div = '0;
    endcase
  end

  always_comb begin
    // Reference decode; reserved code selects none
    o_ref_vdd   = (s_r.pos_reference_sel == 2'h0);
    o_ref_ext   = (s_r.pos_reference_sel == 2'h2);
    o_ref_fixed = (s_r.pos_reference_sel == 2'h3);
  end

  always_comb begin
    // Reserved codes leave the switch open
    o_channel_sel     = s_r.input_channel_sel;
    o_channel_connect = s_r.converter_enable &&
                        chan_valid(s_r.input_channel_sel);
    o_ext_precharge_en   = (s_r.seq == ST_PRE);
    o_ext_precharge_high = s_r.ctl3[`B_EXT_POL] ^ invert;
    o_int_precharge_en   = (s_r.seq == ST_PRE);
    o_int_precharge_high = s_r.ctl3[`B_INT_POL] ^ invert;
    // Extra capacitance is kept off the bus while converting
    o_extra_cap_sel = (s_r.seq == ST_CONV) ? 3'h0 : s_r.extra_cap;
  end

  always_comb begin
    o_bus_pin_lowz_sw = s_r.ctl3[`B_LOWZ_EN];
    o_bus_pin_sw      = s_r.ctl3[`B_PIN_EN];
    o_analog_bus_pin_out = o_int_precharge_high;
    o_analog_bus_pin_oe  = s_r.ctl3[`B_OVR_EN] && (s_r.seq == ST_PRE);
  end

  always_comb begin
    // Guard drives; A flips from acquisition onward
    o_guard_b    = s_r.guard[0] ^ invert;
    o_guard_a    = o_guard_b ^ (s_r.seq == ST_ACQ || s_r.seq == ST_CONV);
    o_guard_a_oe = s_r.converter_enable && s_r.guard[1];
    o_guard_b_oe = s_r.converter_enable && s_r.guard[2];
  end

endmodule

/* verif/cvd_core_model.sv */
module cvd_core_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Converter control
  input  wire logic       i_start,
  input  wire logic [9:0] i_base,
  // Converter answer
  output logic            o_done,
  output logic [9:0]      o_result
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CONV_CLKS = 6;
  int         cnt;
  logic [9:0] n_conv;

  // Result bus toggles outside the done cycle so stale data never matches
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_result <= ~o_result;
    if (!i_resetn) begin
      cnt <= 0;
      n_conv <= 10'h000;
      o_result <= 10'h000;
    end else if (i_start) begin
      cnt <= CONV_CLKS;
    end else if (cnt == 1) begin
      o_done <= 1'b1;
      o_result <= i_base + n_conv;
      n_conv <= n_conv + 10'h001;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* verif/cvd_adc_control_regs_sva.sv */
`include "cvd_adc_consts.svh"

module cvd_adc_sva
  import cvd_adc_pkg::*;
(
  // Clock, reset and bus
  input wire logic               i_clk,
  input wire logic               i_resetn,
  input wire bus_req_t           i_bus,
  input wire logic [`DATA_W-1:0] o_rdata,
  // Sequence
  input wire logic               i_conv_done,
  input wire logic               o_converter_enable,
  input wire logic               o_conv_start,
  input wire logic               o_seq_done,
  // Decodes
  input wire logic               o_conv_clk_rc,
  input wire logic [`DIV_W-1:0]  o_conv_clk_div,
  input wire logic               o_ref_vdd,
  input wire logic               o_ref_ext,
  input wire logic               o_ref_fixed,
  input wire logic [4:0]         o_channel_sel,
  input wire logic               o_channel_connect,
  // Pre-charge and pin
  input wire logic               o_ext_precharge_en,
  input wire logic               o_int_precharge_en,
  input wire logic               o_int_precharge_high,
  input wire logic               o_analog_bus_pin_out,
  input wire logic               o_analog_bus_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_rdata_idle: assert property (
    !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("read data leak");
  a_done_cause: assert property (
    o_seq_done |-> $past(i_conv_done)) else $error("done without core");
  a_done_single: assert property (
    o_seq_done |=> !o_seq_done) else $error("done pulse too long");
  a_connect_enable: assert property (
    o_channel_connect |-> o_converter_enable) else $error("connect when off");
  a_reserved_chan: assert property (
    o_channel_sel inside {5'h05, 5'h06, 5'h07, [5'h14:5'h19], 5'h1C, 5'h1E}
    |-> !o_channel_connect) else $error("reserved channel connected");
  a_pin_override: assert property (
    o_analog_bus_pin_oe |-> o_int_precharge_en &&
    o_analog_bus_pin_out == o_int_precharge_high) else $error("pin override");
  a_ref_select: assert property (
    $onehot0({o_ref_vdd, o_ref_ext, o_ref_fixed})) else $error("ref select");
  a_clk_decode: assert property (
    o_conv_clk_rc |-> o_conv_clk_div == 7'h00) else $error("rc clock divisor");
  a_start_order: assert property (
    o_conv_start |-> !o_ext_precharge_en && !o_seq_done)
    else $error("start during pre-charge");

  c_done: cover property (o_seq_done);
  c_override: cover property (o_analog_bus_pin_oe);
  c_start: cover property (o_conv_start ##1 !o_conv_start);
endmodule

bind cvd_adc_control_regs cvd_adc_sva cvd_adc_sva_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_conv_done(i_conv_done), .o_converter_enable(o_converter_enable),
  .o_conv_start(o_conv_start), .o_seq_done(o_seq_done),
  .o_conv_clk_rc(o_conv_clk_rc), .o_conv_clk_div(o_conv_clk_div),
  .o_ref_vdd(o_ref_vdd), .o_ref_ext(o_ref_ext), .o_ref_fixed(o_ref_fixed),
  .o_channel_sel(o_channel_sel), .o_channel_connect(o_channel_connect),
  .o_ext_precharge_en(o_ext_precharge_en),
  .o_int_precharge_en(o_int_precharge_en),
  .o_int_precharge_high(o_int_precharge_high),
  .o_analog_bus_pin_out(o_analog_bus_pin_out),
  .o_analog_bus_pin_oe(o_analog_bus_pin_oe));

/* verif/testbench.sv */
`include "cvd_adc_consts.svh"

module testbench
  import cvd_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  bus_req_t bus = '0;
  trig_src_t trig = '0;
  logic [9:0] base = 10'h2A5;
  logic [9:0] res;
  logic [7:0] rdata, v;
  logic [6:0] clk_div;
  logic [4:0] chan;
  logic [3:0] pol_hist;
  logic conv_done, conv_en, conv_start, seq_done, clk_rc, connect, ext_en;
  logic ext_high, prev_en, pin_oe, ref_vdd, ref_ext, ref_fixed;
  logic lowz_sw, pin_sw, grd_b;
  int n_fail = 0, n_tests = 0, n_starts = 0, n_done = 0, n_pre = 0, n_oe = 0;
  int s_start, s_done, s_pre, s_oe;
  logic [6:0] divs[8] = '{7'h02, 7'h08, 7'h20, 7'h00,
                          7'h04, 7'h10, 7'h40, 7'h00};
  logic [2:0] refs[4] = '{3'h4, 3'h0, 3'h2, 3'h1};

  always #25 i_clk = ~i_clk;

  cvd_adc_control_regs cvd_adc_control_regs_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata),
    .i_trig(trig), .i_rc_tick(1'b0), .i_conv_done(conv_done),
    .i_conv_result(res), .o_converter_enable(conv_en),
    .o_conv_start(conv_start), .o_seq_done(seq_done), .o_conv_clk_rc(clk_rc),
    .o_conv_clk_div(clk_div), .o_ref_vdd(ref_vdd), .o_ref_ext(ref_ext),
    .o_ref_fixed(ref_fixed), .o_channel_sel(chan), .o_channel_connect(connect),
    .o_ext_precharge_en(ext_en), .o_ext_precharge_high(ext_high),
    .o_int_precharge_en(), .o_int_precharge_high(), .o_extra_cap_sel(),
    .o_bus_pin_lowz_sw(lowz_sw), .o_bus_pin_sw(pin_sw),
    .o_analog_bus_pin_out(), .o_analog_bus_pin_oe(pin_oe), .o_guard_a(),
    .o_guard_a_oe(), .o_guard_b(grd_b), .o_guard_b_oe());

  cvd_core_model cvd_core_model_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_start(conv_start), .i_base(base), .o_done(conv_done), .o_result(res));

  // Polarity history keeps the value at the start of each pre-charge pass
  always @(posedge i_clk) begin
    n_starts <= n_starts + int'(conv_start);
    n_done <= n_done + int'(seq_done);
    n_pre <= n_pre + int'(ext_en);
    n_oe <= n_oe + int'(pin_oe);
    prev_en <= ext_en;
    if (ext_en && !prev_en) pol_hist <= {pol_hist[1:0], ext_high, grd_b};
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    @(negedge i_clk);
    chk(rdata, e);
  endtask

  task automatic convert(input logic [7:0] ctl1, input logic [7:0] ctl3);
    int i;
    s_start = n_starts;
    s_done = n_done;
    s_pre = n_pre;
    s_oe = n_oe;
    bus_wr(`OFF_CTL1, ctl1);
    bus_wr(`OFF_CTL3, ctl3);
    bus_wr(`OFF_PRE, 8'h03);
    bus_wr(`OFF_ACQ, 8'h02);
    bus_wr(`OFF_CTL0, 8'h03);
    rchk(`OFF_STAT, 8'h01);
    for (i = 0; i < 3000 && seq_done !== 1'b1; i++) @(negedge i_clk);
    chk(i < 3000, 1'b1);
    rchk(`OFF_CTL0, 8'h01);
    rchk(`OFF_STAT, 8'h00);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int a = 12'h711; a <= 12'h717; a++) rchk(12'(a), 8'h00);
    chk(conv_en, 1'b0);
    bus_wr(`OFF_LEG_CTL0, 8'hFD);
    rchk(`OFF_CTL0, 8'h7D);
    chk({connect, chan}, 6'h3F);
    bus_wr(`OFF_CTL1, 8'hFF);
    rchk(`OFF_LEG_CTL1, 8'hF3);
    bus_wr(`OFF_STAT, 8'hFF);
    rchk(`OFF_STAT, 8'h00);
    rchk(12'h720, 8'h00);
    for (int c = 0; c < 8; c++) begin
      bus_wr(`OFF_CTL1, {1'b0, 3'(c), 2'b00, 2'(c)});
      chk({clk_rc, clk_div}, {c[1:0] == 2'b11, divs[c]});
      chk({ref_vdd, ref_ext, ref_fixed}, refs[c[1:0]]);
    end
    for (int c = 0; c < 32; c++) begin
      bus_wr(`OFF_CTL0, {1'b0, 5'(c), 2'b01});
      chk(connect, !(c inside {5, 6, 7, [20:25], 28, 30}));
    end
    bus_wr(`OFF_CTL0, 8'h08);
    chk({conv_en, connect}, 2'b00);
    convert(8'h80, 8'h00);
    chk({8'(n_starts - s_start), 8'(n_done - s_done)}, 16'h0101);
    chk(n_pre - s_pre, 16'hC);
    rchk(`OFF_RES0H, 8'h02);
    rchk(`OFF_RES0L, 8'hA5);
    // Model adds its running conversion count to the base
    base = 10'h1C5;
    convert(8'h00, 8'h00);
    rchk(`OFF_RES0H, 8'h71);
    rchk(`OFF_RES0L, 8'h80);
    base = 10'h155;
    bus_wr(`OFF_GRD, 8'hE0);
    convert(8'h80, 8'hFB);
    chk({8'(n_starts - s_start), 8'(n_done - s_done)}, 16'h0201);
    chk({8'(n_pre - s_pre), 8'(n_oe - s_oe)}, 16'h1818);
    chk(pol_hist, 4'hC);
    chk({lowz_sw, pin_sw}, 2'b11);
    rchk(`OFF_CTL3, 8'hFB);
    rchk(`OFF_RES0L, 8'(base + 10'(s_start)));
    rchk(`OFF_RES1L, 8'(base + 10'(s_start + 1)));
    convert(8'h80, 8'hC1);
    chk(pol_hist, 4'hF);
    bus_wr(`OFF_CTL3, 8'h00);
    // Level held well past one conversion: a level trigger would repeat
    for (int s = 0; s < 8; s++) begin
      bus_wr(`OFF_TRIG, {1'b0, 3'(s), 4'h0});
      s_start = n_starts;
      @(posedge i_clk);
      trig <= (s >= 1 && s <= 5) ? 5'(1 << (5 - s)) : 5'h1F;
      repeat (150) @(posedge i_clk);
      trig <= '0;
      chk(n_starts - s_start, (s >= 1 && s <= 5));
    end
    wrap_up();
  end
endmodule
